// ---- include/spm_pkg.sv ----
// constants, pin carriers and state layout for the serial pin reset mux
// assumes one 50 MHz clock and a synchronous active-high reset
package spm_pkg;

   // ==========================================================
   // shared pin mode, latched from the strap at reset release
   localparam logic SPM_MODE_GPIO_UART = 1'h0;
   localparam logic SPM_MODE_SERIAL = 1'h1;

   // ==========================================================
   // pin drive levels (enable is active low)
   localparam logic SPM_OE_N_DRIVE = 1'h0;
   localparam logic SPM_OE_N_FLOAT = 1'h1;
   localparam logic SPM_PIN_IDLE = 1'h0;
   localparam logic SPM_UART_IDLE = 1'h1;
   localparam logic SPM_IN_IDLE = 1'h0;

   // ==========================================================
   // timing
   localparam int SPM_CLOCK_HZ = 50_000_000;
   localparam int SPM_SYNC_STAGES = 2;
   localparam int SPM_SYNC_STAGES_MIN = 2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      SPM_PH_RESET = 2'h0,
      SPM_PH_RUN = 2'h1
   } spm_phase_t;

   // one pin as driven by the device
   typedef struct packed {
      logic o;
      logic oe_n;
   } spm_pin_out_t;

   // one function's request from an inside engine
   typedef struct packed {
      logic data;
      logic drive;
   } spm_drv_t;

   typedef struct packed {
      spm_drv_t data_out;
      spm_drv_t tx_clock;
      spm_drv_t tx_frame_sync;
   } spm_port_b_req_t;

   typedef struct packed {
      spm_drv_t data_out;
      spm_drv_t tx_clock;
      spm_drv_t rx_clock;
   } spm_port_c_req_t;

   typedef struct packed {
      logic tx_clock;
      logic tx_frame_sync;
   } spm_port_b_in_t;

   typedef struct packed {
      logic data_in;
      logic tx_clock;
      logic rx_clock;
   } spm_port_c_in_t;

   // raw pin levels entering the synchroniser
   typedef struct packed {
      logic strap;
      logic b_tx_clock;
      logic b_tx_frame_sync;
      logic c_data_in;
      logic sp_first;
      logic sp_second;
   } spm_pin_in_t;

   typedef struct packed {
      spm_phase_t phase;
      logic mode;
      spm_pin_out_t b_data_out;
      spm_pin_out_t b_tx_clock;
      spm_pin_out_t b_tx_frame_sync;
      spm_pin_out_t c_data_out;
      spm_pin_out_t sp_first;
      spm_pin_out_t sp_second;
      spm_port_b_in_t b_in;
      spm_port_c_in_t c_in;
      logic general_io_line_three_in;
   } spm_state_t;

endpackage : spm_pkg

// ---- design/spm_sync.sv ----
// multi-bit level synchroniser for pin inputs
// assumes each bit is an independent level; no reset so that
// levels keep flowing while the block is held in reset
`timescale 1ns/1ps
module spm_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = spm_pkg::SPM_SYNC_STAGES
) (
   // clock
   input wire logic clock_i,
   // data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   import spm_pkg::*;

   logic [STAGES-1:0][WIDTH-1:0] chain_r;
   logic [STAGES-1:0][WIDTH-1:0] chain_nxt;

   if (STAGES < SPM_SYNC_STAGES_MIN || WIDTH < 1) begin : g_bad_param
      $error("spm_sync needs at least two stages and one bit");
   end

   // stage 0 feeds only stage 1
   always_comb begin
      chain_nxt = {chain_r[STAGES-2:0], async_i};
   end

   always_ff @(posedge clock_i) begin
      chain_r <= chain_nxt;
   end

   assign sync_o = chain_r[STAGES-1];

endmodule : spm_sync

// ---- design/spm_pin_mux.sv ----
// pin reset and multiplexing for serial port b transmit pins and
// the shared pins of serial port c
// assumes engines request drive per function; pins are resolved
// outside from o and oe_n (oe_n low while this block drives)
//
// Functional notes
// - port b data out floats until driven
// - port b tx clock is input after reset
// - port b frame sync input after reset
// - port c data out floats in reset
// - strap low: first shared pin is gpio
// - strap high: first shared pin is tx clock
// - strap low: second shared pin is uart tx
// - strap high: second shared pin is rx clock
// - mode latched at reset release, then frozen
// - uart tx shows one in and after reset
// - gpio line three is input after reset
// - port c tx clock input after reset
// - port c rx clock input after reset
`timescale 1ns/1ps
module spm_pin_mux #(
   // synchroniser depth on pin inputs
   parameter int SYNC_STAGES = spm_pkg::SPM_SYNC_STAGES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // reset-time strap pin
   input wire logic mode_strap_line_i,
   // port b pins
   output logic port_b_serial_data_out_o,
   output logic port_b_serial_data_out_oe_n_o,
   input wire logic port_b_tx_clock_i,
   output logic port_b_tx_clock_o,
   output logic port_b_tx_clock_oe_n_o,
   input wire logic port_b_tx_frame_sync_i,
   output logic port_b_tx_frame_sync_o,
   output logic port_b_tx_frame_sync_oe_n_o,
   // port c dedicated pins
   input wire logic port_c_serial_data_in_i,
   output logic port_c_serial_data_out_o,
   output logic port_c_serial_data_out_oe_n_o,
   // shared pins
   input wire logic shared_pin_first_i,
   output logic shared_pin_first_o,
   output logic shared_pin_first_oe_n_o,
   input wire logic shared_pin_second_i,
   output logic shared_pin_second_o,
   output logic shared_pin_second_oe_n_o,
   // engine requests
   input wire spm_pkg::spm_port_b_req_t port_b_req_i,
   input wire spm_pkg::spm_port_c_req_t port_c_req_i,
   input wire spm_pkg::spm_drv_t general_io_line_three_req_i,
   input wire logic uart_tx_data_i,
   input wire logic uart_tx_active_i,
   // engine-side pin levels
   output spm_pkg::spm_port_b_in_t port_b_in_o,
   output spm_pkg::spm_port_c_in_t port_c_in_o,
   output logic general_io_line_three_in_o,
   // status
   output logic mode_o,
   output logic running_o
);
   import spm_pkg::*;

   // ==========================================================
   // parameter check
   if (SYNC_STAGES < SPM_SYNC_STAGES_MIN) begin : g_bad_stages
      $error("spm_pin_mux needs at least two synchroniser stages");
   end

   // ==========================================================
   // pin input synchroniser
   // every pin level passes the full chain before any logic
   spm_pin_in_t pin_raw;
   spm_pin_in_t pin_s;
   logic [$bits(spm_pin_in_t)-1:0] pin_s_vec;

   always_comb begin
      pin_raw.strap = mode_strap_line_i;
      pin_raw.b_tx_clock = port_b_tx_clock_i;
      pin_raw.b_tx_frame_sync = port_b_tx_frame_sync_i;
      pin_raw.c_data_in = port_c_serial_data_in_i;
      pin_raw.sp_first = shared_pin_first_i;
      pin_raw.sp_second = shared_pin_second_i;
   end

   spm_sync #(
      .WIDTH($bits(spm_pin_in_t)),
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clock_i(clock_i),
      .async_i(pin_raw),
      .sync_o(pin_s_vec)
   );

   assign pin_s = spm_pin_in_t'(pin_s_vec);

   // ==========================================================
   // state
   spm_state_t st_r;
   spm_state_t st_nxt;

   // map one engine request onto a pin
   function automatic spm_pin_out_t drive_pin(input spm_drv_t req);
      spm_pin_out_t p;
      p.o = req.drive ? req.data : SPM_PIN_IDLE;
      p.oe_n = req.drive ? SPM_OE_N_DRIVE : SPM_OE_N_FLOAT;
      return p;
   endfunction : drive_pin

   localparam spm_pin_out_t PIN_FLOAT = '{o: SPM_PIN_IDLE, oe_n: SPM_OE_N_FLOAT};
   localparam spm_pin_out_t PIN_UART_IDLE = '{o: SPM_UART_IDLE, oe_n: SPM_OE_N_DRIVE};
   localparam spm_port_b_in_t B_IN_IDLE = '{tx_clock: SPM_IN_IDLE, tx_frame_sync: SPM_IN_IDLE};
   localparam spm_port_c_in_t C_IN_IDLE = '{
      data_in: SPM_IN_IDLE,
      tx_clock: SPM_IN_IDLE,
      rx_clock: SPM_IN_IDLE
   };

   // uart line idles high whenever it is not sending
   function automatic spm_pin_out_t uart_pin(input logic active, input logic data);
      spm_pin_out_t p;
      p.o = active ? data : SPM_UART_IDLE;
      p.oe_n = SPM_OE_N_DRIVE;
      return p;
   endfunction : uart_pin

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      if (rst_i) begin
         st_nxt.phase = SPM_PH_RESET;
         // strap tracked through reset; last value stays at release
         st_nxt.mode = pin_s.strap;
         st_nxt.b_data_out = PIN_FLOAT;
         st_nxt.b_tx_clock = PIN_FLOAT;
         st_nxt.b_tx_frame_sync = PIN_FLOAT;
         st_nxt.c_data_out = PIN_FLOAT;
         st_nxt.sp_first = PIN_FLOAT;
         if (pin_s.strap == SPM_MODE_GPIO_UART) begin
            st_nxt.sp_second = PIN_UART_IDLE;
         end else begin
            st_nxt.sp_second = PIN_FLOAT;
         end
         st_nxt.b_in = B_IN_IDLE;
         st_nxt.c_in = C_IN_IDLE;
         st_nxt.general_io_line_three_in = SPM_IN_IDLE;
      end else begin
         case (st_r.phase)
            SPM_PH_RESET,
            SPM_PH_RUN: begin
               st_nxt.phase = SPM_PH_RUN;
            end
            default: begin
               st_nxt.phase = SPM_PH_RUN;
            end
         endcase
         // mode is not touched outside reset
         st_nxt.mode = st_r.mode;
         // pins float until their engine asks to drive
         st_nxt.b_data_out = drive_pin(port_b_req_i.data_out);
         st_nxt.b_tx_clock = drive_pin(port_b_req_i.tx_clock);
         st_nxt.b_tx_frame_sync = drive_pin(port_b_req_i.tx_frame_sync);
         st_nxt.c_data_out = drive_pin(port_c_req_i.data_out);
         st_nxt.b_in.tx_clock = pin_s.b_tx_clock;
         st_nxt.b_in.tx_frame_sync = pin_s.b_tx_frame_sync;
         st_nxt.c_in.data_in = pin_s.c_data_in;
         if (st_r.mode == SPM_MODE_GPIO_UART) begin
            st_nxt.sp_first = drive_pin(general_io_line_three_req_i);
            st_nxt.sp_second = uart_pin(uart_tx_active_i, uart_tx_data_i);
            st_nxt.general_io_line_three_in = pin_s.sp_first;
            st_nxt.c_in.tx_clock = SPM_IN_IDLE;
            st_nxt.c_in.rx_clock = SPM_IN_IDLE;
         end else begin
            st_nxt.sp_first = drive_pin(port_c_req_i.tx_clock);
            st_nxt.sp_second = drive_pin(port_c_req_i.rx_clock);
            st_nxt.general_io_line_three_in = SPM_IN_IDLE;
            st_nxt.c_in.tx_clock = pin_s.sp_first;
            st_nxt.c_in.rx_clock = pin_s.sp_second;
         end
      end
   end

   // ==========================================================
   // register
   always_ff @(posedge clock_i) begin
      st_r <= st_nxt;
   end

   // ==========================================================
   // outputs, all from st_r
   // port b pins
   assign port_b_serial_data_out_o = st_r.b_data_out.o;
   assign port_b_serial_data_out_oe_n_o = st_r.b_data_out.oe_n;
   assign port_b_tx_clock_o = st_r.b_tx_clock.o;
   assign port_b_tx_clock_oe_n_o = st_r.b_tx_clock.oe_n;
   assign port_b_tx_frame_sync_o = st_r.b_tx_frame_sync.o;
   assign port_b_tx_frame_sync_oe_n_o = st_r.b_tx_frame_sync.oe_n;

   // port c pins
   assign port_c_serial_data_out_o = st_r.c_data_out.o;
   assign port_c_serial_data_out_oe_n_o = st_r.c_data_out.oe_n;

   // shared pins
   assign shared_pin_first_o = st_r.sp_first.o;
   assign shared_pin_first_oe_n_o = st_r.sp_first.oe_n;
   assign shared_pin_second_o = st_r.sp_second.o;
   assign shared_pin_second_oe_n_o = st_r.sp_second.oe_n;

   // engine side
   assign port_b_in_o = st_r.b_in;
   assign port_c_in_o = st_r.c_in;
   assign general_io_line_three_in_o = st_r.general_io_line_three_in;

   // status
   assign mode_o = st_r.mode;
   assign running_o = (st_r.phase == SPM_PH_RUN);

endmodule : spm_pin_mux

// ---- tb/spm_far_end.sv ----
// far-end pin model: external serial parts and strap board
// assumes a device enable that is low means the device drives
`timescale 1ns/1ps
module spm_far_end (
   // clock
   input wire logic clock_i,
   // device side
   input wire logic [4:0] dev_o_i,
   input wire logic [4:0] dev_oe_n_i,
   // far side
   input wire logic [4:0] ext_en_i,
   input wire logic [4:0] ext_val_i,
   input wire logic strap_i,
   output logic [4:0] pin_o,
   output logic strap_o
);
   // ==========
   // undriven lines wander each cycle
   logic flip_r = 1'b0;
   always_ff @(posedge clock_i) begin
      flip_r <= ~flip_r;
   end
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         pin_o[k] = !dev_oe_n_i[k] ? dev_o_i[k] : (ext_en_i[k] ? ext_val_i[k] : flip_r);
      end
   end
   assign strap_o = strap_i;
endmodule : spm_far_end

// ---- tb/spm_pin_chk_assertions.sv ----
// checker for the mux pin routing and reset levels
// assumes it is bound to spm_pin_mux and sees its ports only
`timescale 1ns/1ps
module spm_pin_chk (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // pins
   input wire logic port_b_serial_data_out_oe_n_o,
   input wire logic port_b_tx_clock_oe_n_o,
   input wire logic port_b_tx_frame_sync_oe_n_o,
   input wire logic port_c_serial_data_out_oe_n_o,
   input wire logic shared_pin_first_o,
   input wire logic shared_pin_first_oe_n_o,
   input wire logic shared_pin_second_o,
   input wire logic shared_pin_second_oe_n_o,
   // engine side
   input wire spm_pkg::spm_port_b_req_t port_b_req_i,
   input wire spm_pkg::spm_port_c_req_t port_c_req_i,
   input wire spm_pkg::spm_drv_t general_io_line_three_req_i,
   input wire logic uart_tx_data_i,
   input wire logic uart_tx_active_i,
   // status
   input wire logic mode_o,
   input wire logic running_o
);
   import spm_pkg::*;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   // ==========
   // pin properties
   sequence s_release;
      $fell(rst_i);
   endsequence
   property p_b_float; !port_b_req_i.data_out.drive |=> port_b_serial_data_out_oe_n_o; endproperty
   a_b_float: assert property (p_b_float) else $error("b data out drives");
   property p_b_rel;
      s_release |-> port_b_tx_clock_oe_n_o && port_b_tx_frame_sync_oe_n_o;
   endproperty
   a_b_rel: assert property (p_b_rel) else $error("b pins not input");
   property p_c_rel; s_release |-> port_c_serial_data_out_oe_n_o; endproperty
   a_c_rel: assert property (p_c_rel) else $error("c data out drives");
   property p_first_gpio;
      !mode_o |=> {shared_pin_first_o, shared_pin_first_oe_n_o} ==
         ($past(general_io_line_three_req_i.drive) ?
         {$past(general_io_line_three_req_i.data), 1'b0} : 2'b01);
   endproperty
   a_first_gpio: assert property (p_first_gpio) else $error("gpio route");
   property p_first_ser;
      mode_o |=> {shared_pin_first_o, shared_pin_first_oe_n_o} ==
         ($past(port_c_req_i.tx_clock.drive) ?
         {$past(port_c_req_i.tx_clock.data), 1'b0} : 2'b01);
   endproperty
   a_first_ser: assert property (p_first_ser) else $error("tx route");
   property p_second_uart; !mode_o |=> {shared_pin_second_o, shared_pin_second_oe_n_o} ==
      ($past(uart_tx_active_i) ? {$past(uart_tx_data_i), 1'b0} : 2'b10); endproperty
   a_second_uart: assert property (p_second_uart) else $error("uart route");
   property p_second_ser;
      mode_o |=> {shared_pin_second_o, shared_pin_second_oe_n_o} ==
         ($past(port_c_req_i.rx_clock.drive) ?
         {$past(port_c_req_i.rx_clock.data), 1'b0} : 2'b01);
   endproperty
   a_second_ser: assert property (p_second_ser) else $error("rx route");
   property p_frozen; !rst_i |=> $stable(mode_o) && running_o; endproperty
   a_frozen: assert property (p_frozen) else $error("mode moved while running");
endmodule : spm_pin_chk

bind spm_pin_mux spm_pin_chk spm_pin_chk_i (.*);

// ---- tb/testbench.sv ----
// bench for the serial pin reset mux: reset levels, both strap modes
// assumes spm_far_end on the pins and the checker bound to the mux
`timescale 1ns/1ps
module testbench;
   import spm_pkg::*;
   // ==========
   // stimulus and observed pins
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic strap = 1'b0;
   logic ua_d = 1'b0;
   logic ua_a = 1'b0;
   spm_port_b_req_t b_req = '0;
   spm_port_c_req_t c_req = '0;
   spm_drv_t g_req = '0;
   logic [4:0] ext_en = '0;
   logic [4:0] ext_val = '0;
   logic [4:0] pin;
   logic [3:0] d_o;
   logic [3:0] d_oe;
   logic strap_pin, b_do, b_do_oe, c_do, c_do_oe, g_in, mode, run;
   spm_port_b_in_t b_in;
   spm_port_c_in_t c_in;
   int n_fail = 0;
   int checks = 0;
   initial begin
      forever #10 clock_i = ~clock_i;
   end
   spm_far_end spm_far_end_i (.clock_i(clock_i), .dev_o_i({1'b0, d_o}), .dev_oe_n_i({1'b1, d_oe}),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .strap_i(strap), .pin_o(pin), .strap_o(strap_pin));
   spm_pin_mux spm_pin_mux_i (.clock_i(clock_i), .rst_i(rst_i), .mode_strap_line_i(strap_pin),
      .port_b_serial_data_out_o(b_do), .port_b_serial_data_out_oe_n_o(b_do_oe),
      .port_b_tx_clock_i(pin[0]), .port_b_tx_clock_o(d_o[0]), .port_b_tx_clock_oe_n_o(d_oe[0]),
      .port_b_tx_frame_sync_i(pin[1]), .port_b_tx_frame_sync_o(d_o[1]),
      .port_b_tx_frame_sync_oe_n_o(d_oe[1]), .port_c_serial_data_in_i(pin[4]),
      .port_c_serial_data_out_o(c_do), .port_c_serial_data_out_oe_n_o(c_do_oe),
      .shared_pin_first_i(pin[2]), .shared_pin_first_o(d_o[2]), .shared_pin_first_oe_n_o(d_oe[2]),
      .shared_pin_second_i(pin[3]), .shared_pin_second_o(d_o[3]),
      .shared_pin_second_oe_n_o(d_oe[3]), .port_b_req_i(b_req), .port_c_req_i(c_req),
      .general_io_line_three_req_i(g_req), .uart_tx_data_i(ua_d), .uart_tx_active_i(ua_a),
      .port_b_in_o(b_in), .port_c_in_o(c_in), .general_io_line_three_in_o(g_in),
      .mode_o(mode), .running_o(run));
   // ==========
   // helpers
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask : tick
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   // ==========
   // scenarios
   task automatic do_reset(input logic s);
      strap = s;
      rst_i = 1'b1;
      tick(20);
      cmp({2'h0, b_do_oe, d_oe[1:0], c_do_oe, d_oe[2], run}, 8'h3e);
      cmp({6'h00, d_o[3], d_oe[3]}, s ? 8'h01 : 8'h02);
      rst_i = 1'b0;
      tick(1);
      cmp({6'h00, mode, run}, {6'h00, s, 1'h1});
      cmp({3'h0, b_do_oe, d_oe[2:0], c_do_oe}, 8'h1f);
      cmp({6'h00, d_o[3], d_oe[3]}, s ? 8'h01 : 8'h02);
      $display("reset with strap %0d done", s);
   endtask : do_reset
   task automatic t_gpio_uart();
      g_req = 2'h3;
      c_req = 6'h07; // c tx clock asks to drive 0, rx clock 1
      ua_a = 1'b1;
      ua_d = 1'b0;
      tick(1);
      cmp({4'h0, d_o[2], d_oe[2], d_o[3], d_oe[3]}, 8'h08);
      g_req = '0;
      ua_a = 1'b0;
      ua_d = 1'b0;
      tick(1);
      cmp({4'h0, d_o[2], d_oe[2], d_o[3], d_oe[3]}, 8'h06);
      ext_en = 5'h14;
      ext_val = 5'h04;
      tick(3);
      cmp({4'h0, g_in, c_in}, 8'h08);
      strap = 1'b1;
      tick(4);
      cmp({7'h00, mode}, 8'h00);
      ext_en = '0;
      c_req = '0;
      $display("gpio and uart mode done");
   endtask : t_gpio_uart
   task automatic t_serial();
      b_req = 6'h3d; // tx frame sync drives 0
      c_req = 6'h3d; // rx clock drives 0
      g_req = 2'h1;
      ua_a = 1'b1;
      ua_d = 1'b1;
      tick(1);
      cmp({2'h0, b_do, b_do_oe, d_o[0], d_oe[0], d_o[1], d_oe[1]}, 8'h28);
      cmp({2'h0, c_do, c_do_oe, d_o[2], d_oe[2], d_o[3], d_oe[3]}, 8'h28);
      b_req = '0;
      c_req = '0;
      g_req = '0;
      ua_a = 1'b0;
      ext_en = 5'h1f;
      ext_val = 5'h1f;
      tick(4);
      cmp({2'h0, b_do_oe, d_oe, c_do_oe}, 8'h3f);
      cmp({2'h0, b_in, c_in, g_in}, 8'h3e);
      strap = 1'b0;
      tick(4);
      cmp({7'h00, mode}, 8'h01);
      ext_en = '0;
      $display("serial mode done");
   endtask : t_serial
   initial begin
      do_reset(1'b0);
      t_gpio_uart();
      do_reset(1'b1);
      t_serial();
      do_reset(1'b0);
      wrap_up();
   end
endmodule : testbench
